/* File: verilog/pwm16_pkg.sv */
// Package: register map, field positions and reset values of the 16-bit pwm module
package pwm16_pkg;

  // Register byte addresses
  localparam logic [7:0] array_control_addr = 8'h00;
  localparam logic [7:0] module_mode_addr   = 8'h04;
  localparam logic [7:0] compare_low_addr   = 8'h08;
  localparam logic [7:0] compare_high_addr  = 8'h0c;
  localparam logic [7:0] counter_addr       = 8'h10;
  localparam logic [7:0] irq_status_addr    = 8'h14;
  localparam logic [7:0] irq_mask_addr      = 8'h18;

  // Array control fields
  localparam int overflow_flag_bit = 7;
  localparam int counter_run_bit   = 6;
  localparam int event_flag_bit    = 0;

  // Module mode fields
  localparam int wide_pwm_bit     = 7;
  localparam int compare_en_bit   = 6;
  localparam int match_en_bit     = 3;
  localparam int pwm_select_bit   = 1;
  localparam int module_irq_bit   = 0;

  // Interrupt status bits
  localparam int irq_match_bit    = 0;
  localparam int irq_overflow_bit = 1;

  // Reset values and counter maximum
  localparam logic [7:0]  mode_reset    = 8'h00;
  localparam logic [15:0] compare_reset = 16'h0000;
  localparam logic [15:0] counter_reset = 16'h0000;
  localparam logic [15:0] counter_max   = 16'hffff;
  localparam logic        run_reset     = 1'b0;

  // AXI responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Register write request carried from the bus slave to the core
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } reg_write_type;

  // Events raised by the pwm core
  typedef struct packed {
    logic match;
    logic overflow;
  } pwm_event_type;

endpackage

/* File: verilog/array_counter.sv */
// Free-running 16-bit array counter with wrap event
`timescale 1ns/10ps
`default_nettype none
module array_counter
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic        run,
  // State
  output logic [15:0]      count,
  output logic             wrap
);

  // One count per clock; wrap from all ones is the overflow
  assign wrap = run && (count == pwm16_pkg::counter_max);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= pwm16_pkg::counter_reset;
    else if (run)
      count <= count + 16'h0001;
  end

endmodule
`default_nettype wire

/* File: verilog/wide_pwm_output.sv */
// Output stage: set on compare match, clear on counter overflow
`timescale 1ns/10ps
`default_nettype none
module wide_pwm_output
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Inputs
  input  wire logic        active,
  input  wire logic        compare_en,
  input  wire logic        match,
  input  wire logic        wrap,
  // Pin
  output logic             pin
);

  // Set wins when set and wrap coincide: compare 0 then never drops,
  // and compare 0xffff is set at the last count for one high clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin <= 1'b0;
    else if (!active || !compare_en)
      pin <= 1'b0;
    else if (match)
      pin <= 1'b1;
    else if (wrap)
      pin <= 1'b0;
  end

endmodule
`default_nettype wire

/* File: verilog/counter_array_pwm16_module.sv */
// Top: one counter array module in 16-bit pwm mode with AXI4-Lite registers
//
// How it works
// (R1) Compare value sets low time per period
// (R2) Counter equals compare drives pin high
// (R3) Counter overflow drives pin low
// (R4) Mode needs compare, pwm and wide selects
// (R5) Match sets event flag when enabled
// (R6) Overflow sets counter overflow flag
// (R7) Software writes low byte before high
// (R8) Low byte write clears compare enable
// (R9) High byte write sets compare enable
// (R10) Compare zero gives output always high
// (R11) Compare 0xffff gives one-clock high time
// (R12) Compare enable clear gives output low
// (R13) Software updates compare on match interrupts
// (R14) Wide mode independent of narrow pwm modes
// (R15) Counter increments, wraps all-ones to zero
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module counter_array_pwm16_module
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pin and interrupt
  output logic             pwm_pin_out,
  output logic             irq
);

  logic [7:0]  aw_addr_reg;
  logic        aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_full_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  logic [7:0]  module_mode_reg;
  logic [15:0] compare_value_reg;
  logic        counter_run_reg;
  logic        counter_overflow_flag_reg;
  logic        module_event_flag_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_mask_reg;

  logic [15:0] count;
  logic        wrap;
  logic        match;
  logic        wide_active;
  logic        compare_enable;
  logic [15:0] count_ahead;
  logic        rise;
  pwm16_pkg::reg_write_type wr;
  pwm16_pkg::pwm_event_type ev;

  // Write channel: address and data taken in either order, one write at a time
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (wr.valid)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (wr.valid)
      w_full_reg <= 1'b0;
  end

  always_comb
  begin
    wr.valid = aw_full_reg && w_full_reg;
    wr.addr  = {aw_addr_reg[7:2], 2'b00};
    wr.data  = w_data_reg;
    wr.strb  = w_strb_reg;
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pwm16_pkg::array_control_addr) || (a == pwm16_pkg::module_mode_addr) ||
             (a == pwm16_pkg::compare_low_addr) || (a == pwm16_pkg::compare_high_addr) ||
             (a == pwm16_pkg::counter_addr) || (a == pwm16_pkg::irq_status_addr) ||
             (a == pwm16_pkg::irq_mask_addr);
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pwm16_pkg::resp_okay;
    end
    // Unmapped writes are answered with an error and change nothing
    else if (wr.valid)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= mapped(wr.addr) ? pwm16_pkg::resp_okay : pwm16_pkg::resp_slverr;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // Every writable register fits in one byte, so the upper byte lanes are ignored
  logic wr_lane0;
  assign wr_lane0 = wr.valid && wr.strb[0];

  // Mode register; byte writes to the compare value steer compare enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      module_mode_reg <= pwm16_pkg::mode_reset;
    else if (wr_lane0 && wr.addr == pwm16_pkg::module_mode_addr)
      module_mode_reg <= wr.data[7:0];
    // (R8) low byte clears enable
    else if (wr_lane0 && wr.addr == pwm16_pkg::compare_low_addr)
      module_mode_reg[pwm16_pkg::compare_en_bit] <= 1'b0;
    // (R9) high byte sets enable
    else if (wr_lane0 && wr.addr == pwm16_pkg::compare_high_addr)
      module_mode_reg[pwm16_pkg::compare_en_bit] <= 1'b1;
  end

  // (R7) Bytes stored independently; low-then-high order keeps the output off between them
  // A lone high byte write re-enables with whatever low byte is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_value_reg <= pwm16_pkg::compare_reset;
    else if (wr_lane0 && wr.addr == pwm16_pkg::compare_low_addr)
      compare_value_reg[7:0] <= wr.data[7:0];
    else if (wr_lane0 && wr.addr == pwm16_pkg::compare_high_addr)
      compare_value_reg[15:8] <= wr.data[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      counter_run_reg <= pwm16_pkg::run_reset;
    else if (wr_lane0 && wr.addr == pwm16_pkg::array_control_addr)
      counter_run_reg <= wr.data[pwm16_pkg::counter_run_bit];
  end

  // Stopping the counter freezes the pin at its present level
  // (R15) Shared counter
  array_counter u_counter
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (counter_run_reg),
    .count   (count),
    .wrap    (wrap)
  );

  // (R4) Wide mode select
  assign compare_enable = module_mode_reg[pwm16_pkg::compare_en_bit];
  assign wide_active    = compare_enable && module_mode_reg[pwm16_pkg::pwm_select_bit] &&
                          module_mode_reg[pwm16_pkg::wide_pwm_bit];
  // (R2) Comparator match, one per count value; it drives the event flag
  assign match = wide_active && counter_run_reg && (count == compare_value_reg);

  // The pin is a flip-flop, so it is set one count early and then stands
  // high from the very clock in which the counter equals the compare value
  // (R1) Low for exactly compare clocks per period
  assign count_ahead = count + 16'h0001;
  assign rise        = wide_active && counter_run_reg && (count_ahead == compare_value_reg);

  // (R3) Overflow drives low, (R12) disabled gives low
  wide_pwm_output u_output
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .active     (wide_active),
    .compare_en (compare_enable),
    .match      (rise),
    .wrap       (wrap),
    .pin        (pwm_pin_out)
  );
  // (R10) Compare zero: set and wrap coincide, set wins, pin never drops
  // (R11) Compare 0xffff: set at the last count, high for one clock
  // (R14) Period is always the full 16-bit wrap, no reload from other modes

  always_comb
  begin
    ev.match    = match && module_mode_reg[pwm16_pkg::match_en_bit];
    ev.overflow = wrap;
  end

  // Software may also set a flag by writing a one to it
  logic clr_ctrl;
  assign clr_ctrl = wr_lane0 && wr.addr == pwm16_pkg::array_control_addr;

  // (R6) Overflow flag; set wins over a clearing write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      counter_overflow_flag_reg <= 1'b0;
    else if (ev.overflow)
      counter_overflow_flag_reg <= 1'b1;
    else if (clr_ctrl)
      counter_overflow_flag_reg <= wr.data[pwm16_pkg::overflow_flag_bit];
  end

  // (R5) Match event flag; set wins over a clearing write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      module_event_flag_reg <= 1'b0;
    else if (ev.match)
      module_event_flag_reg <= 1'b1;
    else if (clr_ctrl)
      module_event_flag_reg <= wr.data[pwm16_pkg::event_flag_bit];
  end

  // Sticky interrupt status, write one to clear, set wins
  // Overflow is reported whatever the mode; the match needs its enable
  logic [1:0] ev_vec;
  logic [1:0] w1c;
  assign ev_vec = {ev.overflow, ev.match && module_mode_reg[pwm16_pkg::module_irq_bit]};
  assign w1c    = (wr_lane0 && wr.addr == pwm16_pkg::irq_status_addr) ? wr.data[1:0] : 2'b00;

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_status
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          irq_status_reg[i] <= 1'b0;
        else if (ev_vec[i])
          irq_status_reg[i] <= 1'b1;
        else if (w1c[i])
          irq_status_reg[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_reg <= 2'b00;
    else if (wr_lane0 && wr.addr == pwm16_pkg::irq_mask_addr)
      irq_mask_reg <= wr.data[1:0];
  end

  // (R13) Match interrupt lets software re-time compare updates
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read channel: one read at a time, answer one cycle after address
  // Reads have no side effect; flags clear only by writes
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  logic [7:0] ra;
  assign ra = {s_axi_araddr[7:2], 2'b00};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pwm16_pkg::resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= pwm16_pkg::resp_okay;
      if (ra == pwm16_pkg::array_control_addr)
        rdata_reg <= {24'h000000, counter_overflow_flag_reg, counter_run_reg, 5'h00, module_event_flag_reg};
      else if (ra == pwm16_pkg::module_mode_addr)
        rdata_reg <= {24'h000000, module_mode_reg};
      else if (ra == pwm16_pkg::compare_low_addr)
        rdata_reg <= {24'h000000, compare_value_reg[7:0]};
      else if (ra == pwm16_pkg::compare_high_addr)
        rdata_reg <= {24'h000000, compare_value_reg[15:8]};
      else if (ra == pwm16_pkg::counter_addr)
        rdata_reg <= {16'h0000, count};
      else if (ra == pwm16_pkg::irq_status_addr)
        rdata_reg <= {30'h0, irq_status_reg};
      else if (ra == pwm16_pkg::irq_mask_addr)
        rdata_reg <= {30'h0, irq_mask_reg};
      else
      begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= pwm16_pkg::resp_slverr;
      end
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule
`default_nettype wire

/* File: test/pwm16_props.sv */
// Checker: bus handshake and pin properties of the wide pwm module
`timescale 1ns/10ps
`default_nettype none
module pwm16_props
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pin
  input wire logic        pwm_pin_out
);
  logic [7:0] wa_reg;
  logic       lane_reg;
  logic       mode_ok_reg;

  // Remember the write target so the response edge can be judged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wa_reg <= 8'h00;
    else if (s_axi_awvalid && s_axi_awready)
      wa_reg <= s_axi_awaddr;
  end

  // Mode value 8'hc2 holds the wide, compare and pwm selects
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lane_reg    <= 1'b0;
      mode_ok_reg <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      lane_reg    <= s_axi_wstrb[0];
      mode_ok_reg <= (s_axi_wdata[7:0] & 8'hc2) == 8'hc2;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w_take; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_resp; $rose(s_axi_bvalid) && s_axi_bresp == pwm16_pkg::resp_okay && lane_reg; endsequence

  property p_aw_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_wr_lat; s_aw_take and s_w_take |-> ##[1:2] s_axi_bvalid; endproperty
  property p_slverr; s_axi_rvalid && s_axi_rresp == pwm16_pkg::resp_slverr |-> s_axi_rdata == 32'h0; endproperty
  property p_low_off;
    s_resp ##0 wa_reg == pwm16_pkg::compare_low_addr |=> !pwm_pin_out [*2];
  endproperty
  property p_mode_off;
    s_resp ##0 (wa_reg == pwm16_pkg::module_mode_addr && !mode_ok_reg) |=> !pwm_pin_out [*2];
  endproperty

  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while response pending");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while data pending");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  a_slverr: assert property (p_slverr) else $error("unmapped read data not zero");
  a_low_off: assert property (p_low_off) else $error("pin high after low byte write");
  a_mode_off: assert property (p_mode_off) else $error("pin high outside wide mode");
endmodule

bind counter_array_pwm16_module pwm16_props u_props
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_pin_out
);
`default_nettype wire

/* File: test/tb_counter_array_pwm16_module.sv */
// Testbench: registers, pwm timing and interrupt of the wide pwm module
`timescale 1ns/10ps
`default_nettype none
module tb_counter_array_pwm16_module;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pwm_pin_out, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] cmp;
  int          err_count, check_count, cycles, n;

  counter_array_pwm16_module dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pwm_pin_out, .irq
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // One full counter period plus register traffic fits well inside this
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pwm16_pkg::resp_okay);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er = pwm16_pkg::resp_okay);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic t_reset();
    logic [7:0] al [7];
    al = '{pwm16_pkg::array_control_addr, pwm16_pkg::module_mode_addr, pwm16_pkg::compare_low_addr,
           pwm16_pkg::compare_high_addr, pwm16_pkg::counter_addr, pwm16_pkg::irq_status_addr,
           pwm16_pkg::irq_mask_addr};
    foreach (al[i])
    begin
      rd(al[i]);
      chk(rv, 32'h0);
    end
    chk({30'h0, irq, pwm_pin_out}, 32'h0);
  endtask

  task automatic t_unmapped();
    wr(8'h1c, 32'h000000ff, pwm16_pkg::resp_slverr);
    rd(8'h1c, pwm16_pkg::resp_slverr);
    chk(rv, 32'h0);
  endtask

  // Compare set a little above the running count, so one period is measured
  task automatic t_pwm();
    wr(pwm16_pkg::irq_mask_addr, 32'h3);
    wr(pwm16_pkg::module_mode_addr, 32'h8b);
    wr(pwm16_pkg::array_control_addr, 32'h40);
    rd(pwm16_pkg::counter_addr);
    cmp = rv[15:0] + 16'h0040;
    wr(pwm16_pkg::compare_low_addr, {24'h0, cmp[7:0]});
    wr(pwm16_pkg::compare_high_addr, {24'h0, cmp[15:8]});
    n = 0;
    while (pwm_pin_out !== 1'b1 && n < 256)
    begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, pwm_pin_out}, 32'h1);
    n = 0;
    while (pwm_pin_out === 1'b1)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n, 32'h10000 - cmp);
    n = 0;
    while (pwm_pin_out !== 1'b1)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n, {16'h0, cmp});
  endtask

  task automatic t_irq();
    rd(pwm16_pkg::array_control_addr);
    chk(rv, 32'hc1);
    rd(pwm16_pkg::irq_status_addr);
    chk(rv, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(pwm16_pkg::irq_mask_addr, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(pwm16_pkg::irq_mask_addr, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(pwm16_pkg::irq_status_addr, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(pwm16_pkg::irq_status_addr);
    chk(rv, 32'h2);
    wr(pwm16_pkg::irq_status_addr, 32'h2);
    rd(pwm16_pkg::irq_status_addr);
    chk(rv, 32'h0);
    wr(pwm16_pkg::array_control_addr, 32'h40);
    rd(pwm16_pkg::array_control_addr);
    chk(rv, 32'h40);
  endtask

  // Pin is high here, so the low byte write must cut the pulse short
  task automatic t_enable();
    wr(pwm16_pkg::compare_low_addr, {24'h0, cmp[7:0]});
    rd(pwm16_pkg::module_mode_addr);
    chk(rv, 32'h8b);
    chk({31'h0, pwm_pin_out}, 32'h0);
    // A fresh compare just ahead of the count brings the pin up again soon
    rd(pwm16_pkg::counter_addr);
    cmp = rv[15:0] + 16'h0040;
    wr(pwm16_pkg::compare_low_addr, {24'h0, cmp[7:0]});
    wr(pwm16_pkg::compare_high_addr, {24'h0, cmp[15:8]});
    rd(pwm16_pkg::module_mode_addr);
    chk(rv, 32'hcb);
    n = 0;
    while (pwm_pin_out !== 1'b1 && n < 256)
    begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, pwm_pin_out}, 32'h1);
    wr(pwm16_pkg::module_mode_addr, 32'hc9);
    rd(pwm16_pkg::module_mode_addr);
    chk(rv, 32'hc9);
    chk({31'h0, pwm_pin_out}, 32'h0);
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_pwm();
    t_irq();
    t_enable();
    end_of_test();
  end
endmodule
`default_nettype wire
